// ---- hdl/uart_sfr_defines.vh ----
`ifndef UART_SFR_DEFINES_VH
`define UART_SFR_DEFINES_VH

// special-function-register addresses
`define UART_SBUF_ADDR   8'h99
`define UART_CTRL_ADDR   8'h98

// control register field positions
`define CTRL_MODE9_BIT   7
`define CTRL_UNUSED_BIT  6
`define CTRL_MCE_BIT     5
`define CTRL_REN_BIT     4
`define CTRL_TB8_BIT     3
`define CTRL_RB8_BIT     2
`define CTRL_TI_BIT      1
`define CTRL_RI_BIT      0

// reset values
`define SBUF_RST         8'h00
`define BIT_RST          1'b0
`define UNUSED_READ      1'b1
`define RDATA_ZERO       8'h00

// serial timing: bit period from clock and baud rate
`define UART_CLK_HZ      100000000
`define UART_BAUD        115200
`define BIT_CYCLES       (`UART_CLK_HZ / `UART_BAUD)

// frame counts
`define DATA_BITS        4'h8
`define CNT_ZERO         16'h0000
`define BITCNT_ZERO      4'h0
`define BITCNT_ONE       4'h1

// transmit and receive states
`define TX_IDLE          3'h0
`define TX_START         3'h1
`define TX_DATA          3'h2
`define TX_NINTH         3'h3
`define TX_STOP          3'h4
`define RX_IDLE          3'h0
`define RX_START         3'h1
`define RX_DATA          3'h2
`define RX_NINTH         3'h3
`define RX_STOP          3'h4

`endif

// ---- hdl/uart_tx_queue.v ----
`timescale 1ns/1ns
// two-entry queue, keeps a byte written while the shifter is busy
module uart_tx_queue
(
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  input  wire       in_valid_i,
  output wire       in_ready_o,
  input  wire [8:0] in_data_i,
  output wire       out_valid_o,
  input  wire       out_ready_i,
  output wire [8:0] out_data_o
);

  reg [8:0] mem_q [0:1];
  reg       wr_ptr_q;
  reg       rd_ptr_q;
  reg [1:0] count_q;
  wire      push;
  wire      pop;

  assign in_ready_o  = (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      count_q    <= 2'h0;
      mem_q[0]   <= 9'h000;
      mem_q[1]   <= 9'h000;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        mem_q[wr_ptr_q] <= in_data_i;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push & ~pop)
        count_q <= count_q + 2'h1;
      else if (pop & ~push)
        count_q <= count_q - 2'h1;
    end
  end

endmodule

// ---- hdl/uart_data_buffer_and_flags.v ----
`timescale 1ns/1ns
//
// Contract
// - one data address: writes reach transmit shifter, reads receive latch
// - byte the queue accepts is held until it has been shifted out
// - each data write the queue accepts starts a transmission, no other command needed
// - data read returns the receive latch, never the pending transmit byte
// - 9-bit framing sends software ninth bit after the eight data bits
// - receive ninth-bit flag takes ninth bit, or stop bit in 8-bit framing
// - transmit-complete flag sets at start of the stop-bit time
// - at mid stop bit, load latch and flag only if flag clear, check passes
//
module uart_data_buffer_and_flags
(
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire       sfr_rd_i,
  input  wire [7:0] sfr_wdata_i,
  output reg  [7:0] sfr_rdata_o,
  output wire       tx_ready_o,
  input  wire       rx_i,
  output reg        tx_o
);

`include "uart_sfr_defines.vh"

  localparam [31:0] BIT_FULL = `BIT_CYCLES;
  localparam [31:0] BIT_HALF = `BIT_CYCLES / 2;
  localparam [15:0] BIT_LAST = BIT_FULL[15:0] - 16'h0001;
  localparam [15:0] HALF_LAST = BIT_HALF[15:0] - 16'h0001;

  //////////////////////////////////////////////////////////////////////////
  // control register and decode

  reg        mode9_q;
  reg        mce_q;
  reg        ren_q;
  reg        tx_ninth_bit_q;
  reg        rx_ninth_bit_q;
  reg        tx_complete_flag_q;
  reg        rx_complete_flag_q;
  reg  [7:0] rx_latch_q;
  reg  [7:0] rx_sh_q;
  wire       wr_data;
  wire       wr_ctrl;
  wire       set_ti;
  wire       set_ri;
  wire       rb8_value;
  wire [7:0] ctrl_view;

  assign wr_data = sfr_wr_i & (sfr_addr_i == `UART_SBUF_ADDR);
  assign wr_ctrl = sfr_wr_i & (sfr_addr_i == `UART_CTRL_ADDR);

  assign ctrl_view = {mode9_q, `UNUSED_READ, mce_q, ren_q, tx_ninth_bit_q,
                      rx_ninth_bit_q, tx_complete_flag_q, rx_complete_flag_q};

  // flags: a hardware set in the same cycle as a software write wins
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode9_q            <= `BIT_RST;
      mce_q              <= `BIT_RST;
      ren_q              <= `BIT_RST;
      tx_ninth_bit_q     <= `BIT_RST;
      rx_ninth_bit_q     <= `BIT_RST;
      tx_complete_flag_q <= `BIT_RST;
      rx_complete_flag_q <= `BIT_RST;
      rx_latch_q         <= `SBUF_RST;
      sfr_rdata_o        <= `RDATA_ZERO;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        mode9_q        <= sfr_wdata_i[`CTRL_MODE9_BIT];
        mce_q          <= sfr_wdata_i[`CTRL_MCE_BIT];
        ren_q          <= sfr_wdata_i[`CTRL_REN_BIT];
        tx_ninth_bit_q <= sfr_wdata_i[`CTRL_TB8_BIT];
      end
      if (set_ri)
      begin
        rx_latch_q     <= rx_sh_q;
        rx_ninth_bit_q <= rb8_value;
      end
      else if (wr_ctrl)
        rx_ninth_bit_q <= sfr_wdata_i[`CTRL_RB8_BIT];
      // only software takes these down
      if (set_ti)
        tx_complete_flag_q <= 1'b1;
      else if (wr_ctrl)
        tx_complete_flag_q <= sfr_wdata_i[`CTRL_TI_BIT];
      if (set_ri)
        rx_complete_flag_q <= 1'b1;
      else if (wr_ctrl)
        rx_complete_flag_q <= sfr_wdata_i[`CTRL_RI_BIT];
      if (sfr_rd_i & (sfr_addr_i == `UART_SBUF_ADDR))
        sfr_rdata_o <= rx_latch_q;
      else if (sfr_rd_i & (sfr_addr_i == `UART_CTRL_ADDR))
        sfr_rdata_o <= ctrl_view;
      else if (sfr_rd_i)
        sfr_rdata_o <= `RDATA_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit queue and shifter

  wire        q_valid;
  wire [8:0]  q_data;
  wire        q_pop;
  reg  [2:0]  tx_state_q;
  reg  [15:0] tx_cnt_q;
  reg  [3:0]  tx_bits_q;
  reg  [8:0]  tx_sh_q;
  wire        tx_tick;

  // a write while both entries are full is dropped; poll tx_ready_o first
  uart_tx_queue u_queue
  (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (wr_data),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_ninth_bit_q, sfr_wdata_i}),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_data)
  );

  assign q_pop   = (tx_state_q == `TX_IDLE);
  assign tx_tick = (tx_cnt_q == `CNT_ZERO);
  assign set_ti  = tx_tick & (((tx_state_q == `TX_DATA) & ~mode9_q &
                   (tx_bits_q == `BITCNT_ONE)) | (tx_state_q == `TX_NINTH));

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_state_q <= `TX_IDLE;
      tx_cnt_q   <= `CNT_ZERO;
      tx_bits_q  <= `BITCNT_ZERO;
      tx_sh_q    <= 9'h000;
      tx_o       <= 1'b1;
    end
    else if (ce_i)
    begin
      tx_cnt_q <= tx_tick ? BIT_LAST : tx_cnt_q - 16'h0001;
      case (tx_state_q)
        `TX_IDLE:
        begin
          tx_o <= 1'b1;
          if (q_valid)
          begin
            tx_sh_q    <= q_data;
            tx_o       <= 1'b0;
            tx_cnt_q   <= BIT_LAST;
            tx_state_q <= `TX_START;
          end
        end
        `TX_START:
          if (tx_tick)
          begin
            tx_o       <= tx_sh_q[0];
            tx_sh_q    <= {1'b0, tx_sh_q[8:1]};
            tx_bits_q  <= `DATA_BITS;
            tx_state_q <= `TX_DATA;
          end
        `TX_DATA:
          if (tx_tick)
          begin
            tx_bits_q <= tx_bits_q - `BITCNT_ONE;
            if (tx_bits_q != `BITCNT_ONE)
            begin
              tx_o    <= tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            end
            else if (mode9_q)
            begin
              tx_o       <= tx_sh_q[0];
              tx_state_q <= `TX_NINTH;
            end
            else
            begin
              tx_o       <= 1'b1;
              tx_state_q <= `TX_STOP;
            end
          end
        `TX_NINTH:
          if (tx_tick)
          begin
            tx_o       <= 1'b1;
            tx_state_q <= `TX_STOP;
          end
        `TX_STOP:
          if (tx_tick)
            tx_state_q <= `TX_IDLE;
        default:
          tx_state_q <= `TX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receiver: three-stage pin filter, mid-bit sampling

  reg         rx_s1_q;
  reg         rx_s2_q;
  reg         rx_s3_q;
  reg         rx_line_q;
  reg  [2:0]  rx_state_q;
  reg  [15:0] rx_cnt_q;
  reg  [3:0]  rx_bits_q;
  reg         rx_bit9_q;
  wire        rx_tick;
  wire        accept;

  assign rx_tick   = (rx_cnt_q == `CNT_ZERO);
  assign rb8_value = mode9_q ? rx_bit9_q : rx_line_q;
  // multiprocessor check looks at ninth bit, or stop level in 8-bit framing
  assign accept    = ~rx_complete_flag_q & (~mce_q | rb8_value);
  assign set_ri    = (rx_state_q == `RX_STOP) & rx_tick & accept;

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_s1_q    <= 1'b1;
      rx_s2_q    <= 1'b1;
      rx_s3_q    <= 1'b1;
      rx_line_q  <= 1'b1;
      rx_state_q <= `RX_IDLE;
      rx_cnt_q   <= `CNT_ZERO;
      rx_bits_q  <= `BITCNT_ZERO;
      rx_sh_q    <= `SBUF_RST;
      rx_bit9_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_s1_q <= rx_i;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q)
        rx_line_q <= rx_s3_q;
      rx_cnt_q <= rx_tick ? BIT_LAST : rx_cnt_q - 16'h0001;
      case (rx_state_q)
        `RX_IDLE:
          if (ren_q & ~rx_line_q)
          begin
            rx_cnt_q   <= HALF_LAST;
            rx_state_q <= `RX_START;
          end
        `RX_START:
          if (rx_tick)
          begin
            // a glitch shorter than half a bit is not a start
            rx_state_q <= rx_line_q ? `RX_IDLE : `RX_DATA;
            rx_bits_q  <= `DATA_BITS;
          end
        `RX_DATA:
          if (rx_tick)
          begin
            rx_sh_q   <= {rx_line_q, rx_sh_q[7:1]};
            rx_bits_q <= rx_bits_q - `BITCNT_ONE;
            if (rx_bits_q == `BITCNT_ONE)
              rx_state_q <= mode9_q ? `RX_NINTH : `RX_STOP;
          end
        `RX_NINTH:
          if (rx_tick)
          begin
            rx_bit9_q  <= rx_line_q;
            rx_state_q <= `RX_STOP;
          end
        `RX_STOP:
          if (rx_tick)
            rx_state_q <= `RX_IDLE;
        default:
          rx_state_q <= `RX_IDLE;
      endcase
    end
  end

endmodule

// ---- bench/uart_checker_props.sv ----
`timescale 1ns/1ns
`include "uart_sfr_defines.vh"
module uart_checker
(
  input wire       clk_i,
  input wire       sys_rst_i,
  input wire       ce_i,
  input wire [7:0] sfr_addr_i,
  input wire       sfr_wr_i,
  input wire       sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire       tx_ready_o,
  input wire       rx_i,
  input wire       tx_o
);
  reg        last_q;
  reg [15:0] run_q;
  // length of the current level run on the line, for bit timing
  always @(posedge clk_i)
  begin
    last_q <= sys_rst_i | tx_o;
    run_q  <= (sys_rst_i || tx_o != last_q) ? 16'h0001 : run_q + 16'h0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_idle: assert property ($fell(sys_rst_i) |->
    tx_o && tx_ready_o && sfr_rdata_o == 8'h00) else $error("bad reset");
  a_rdata_holds: assert property (!(ce_i && sfr_rd_i) |=>
    $stable(sfr_rdata_o)) else $error("read data moved");
  a_unmapped_zero: assert property (ce_i && sfr_rd_i &&
    sfr_addr_i != `UART_SBUF_ADDR && sfr_addr_i != `UART_CTRL_ADDR
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_ctrl_bit6: assert property (ce_i && sfr_rd_i &&
    sfr_addr_i == `UART_CTRL_ADDR |=> sfr_rdata_o[6])
    else $error("unused bit not one");
  a_ready_cause: assert property ($fell(tx_ready_o) |->
    $past(ce_i && sfr_wr_i && sfr_addr_i == `UART_SBUF_ADDR))
    else $error("queue filled without write");
  a_bit_timing: assert property (tx_o && !last_q |->
    run_q % `BIT_CYCLES == 0) else $error("low run not whole bits");
  a_frame_bound: assert property (!last_q |->
    run_q <= 16'h21E8) else $error("low run too long");
  a_write_starts: assert property (ce_i && sfr_wr_i &&
    sfr_addr_i == `UART_SBUF_ADDR && run_q > 16'h2710 && tx_o
    |-> ##[1:3] !tx_o) else $error("write did not start frame");
endmodule
bind uart_data_buffer_and_flags uart_checker uart_checker_inst
(
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
  .tx_ready_o(tx_ready_o), .rx_i(rx_i), .tx_o(tx_o)
);

// ---- bench/uart_remote_node.sv ----
`timescale 1ns/1ns
`include "uart_sfr_defines.vh"
module uart_remote_node
(
  input  wire tx_i,
  input  wire nine_i,
  output reg  rx_o
);
  localparam integer BIT_NS = `BIT_CYCLES * 10;
  reg [7:0] got_q [0:7];
  reg       ninth_q;
  integer   frames;
  integer   i;
  initial
  begin
    rx_o = 1'b1;
    frames = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // sample at mid bit so the design's edge placement need not be exact
  always @(negedge tx_i)
  begin
    #(BIT_NS / 2);
    for (i = 0; i < 8; i = i + 1)
    begin
      #(BIT_NS);
      got_q[frames[2:0]][i] = tx_i;
    end
    if (nine_i)
    begin
      #(BIT_NS);
      ninth_q = tx_i;
    end
    frames = frames + 1;
  end
  task send(input [7:0] data, input ninth, input nine);
    integer k;
    begin
      rx_o = 1'b0;
      #(BIT_NS);
      for (k = 0; k < 8; k = k + 1)
      begin
        rx_o = data[k];
        #(BIT_NS);
      end
      if (nine)
      begin
        rx_o = ninth;
        #(BIT_NS);
      end
      // stop bit, then idle long enough for the mid-stop decision
      rx_o = 1'b1;
      #(BIT_NS * 2);
    end
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`include "uart_sfr_defines.vh"
module testbench;
  reg         clk_i;
  reg         sys_rst_i;
  reg         ce_i;
  reg         sfr_wr_i;
  reg         sfr_rd_i;
  reg         nine;
  reg  [7:0]  sfr_addr_i;
  reg  [7:0]  sfr_wdata_i;
  wire [7:0]  sfr_rdata_o;
  wire        tx_ready_o;
  wire        rx_i;
  wire        tx_o;
  integer     errors;
  integer     samples_checked;
  integer     cycles;
  uart_data_buffer_and_flags uart_data_buffer_and_flags_inst
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .tx_ready_o(tx_ready_o), .rx_i(rx_i), .tx_o(tx_o)
  );
  uart_remote_node uart_remote_node_inst
  (
    .tx_i(tx_o), .nine_i(nine), .rx_o(rx_i)
  );
  ////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 100000)
    begin
      errors = errors + 1;
      close_out;
    end
  end
  task close_out;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task check(input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge clk_i);
      sfr_wr_i = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge clk_i);
      sfr_rd_i = 1'b0;
      check(sfr_rdata_o, exp);
    end
  endtask
  // global cycle ceiling cuts this wait short on a hang
  task wait_frames(input integer n);
    begin
      wait (uart_remote_node_inst.frames >= n);
      repeat (`BIT_CYCLES) @(negedge clk_i);
    end
  endtask
  initial
  begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    nine = 1'b0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(8'h99, 8'h00);
    rd(8'h98, 8'h40);
    rd(8'h55, 8'h00);
    wr(8'h99, 8'h3C);
    wr(8'h99, 8'hC3);
    wr(8'h99, 8'h0F);
    check({7'h00, tx_ready_o}, 8'h00);
    wr(8'h99, 8'hEE);
    rd(8'h99, 8'h00);
    wait_frames(3);
    check(uart_remote_node_inst.got_q[0], 8'h3C);
    check(uart_remote_node_inst.got_q[1], 8'hC3);
    check(uart_remote_node_inst.got_q[2], 8'h0F);
    rd(8'h98, 8'h42);
    wr(8'h98, 8'h10);
    uart_remote_node_inst.send(8'h96, 1'b0, 1'b0);
    rd(8'h98, 8'h55);
    rd(8'h99, 8'h96);
    uart_remote_node_inst.send(8'h11, 1'b0, 1'b0);
    rd(8'h99, 8'h96);
    wr(8'h98, 8'hB0);
    uart_remote_node_inst.send(8'h22, 1'b0, 1'b1);
    rd(8'h98, 8'hF0);
    uart_remote_node_inst.send(8'h33, 1'b1, 1'b1);
    rd(8'h98, 8'hF5);
    rd(8'h99, 8'h33);
    wr(8'h98, 8'h88);
    nine = 1'b1;
    wr(8'h99, 8'h5A);
    wait_frames(4);
    check(uart_remote_node_inst.got_q[3], 8'h5A);
    check({7'h00, uart_remote_node_inst.ninth_q}, 8'h01);
    rd(8'h98, 8'hCA);
    // a flag clear while the clock enable is low must not land
    ce_i = 1'b0;
    wr(8'h98, 8'h00);
    ce_i = 1'b1;
    rd(8'h98, 8'hCA);
    close_out;
  end
endmodule
